// ---- pfsp_array.sv ----
// Flash array model: one panel of rows with erase and row program
`timescale 1ns/1ps
module pfsp_array
    import pfsp_pkg::*;
#(
    parameter int unsigned ROWS = PANEL_ROWS
) (
    input  wire logic sys_clk,
    input  wire logic rst,
    pfsp_array_if.arr a
);
    logic [23:0] mem [ROWS*ROW_WORDS];
    logic [23:0] latch_q;
    logic [4:0]  copy_idx;
    logic        copying;
    logic [$clog2(ROWS)-1:0] row;
    logic [$clog2(ROWS*ROW_WORDS)-1:0] rd_w;

    // Row address is a byte address: bit 6 upward selects the row
    assign row  = a.row_addr[6 +: $clog2(ROWS)];
    assign rd_w = a.rd_addr[0 +: $clog2(ROWS*ROW_WORDS)];

    pfsp_latch #(.WORDS(ROW_WORDS)) u_latch (
        .sys_clk (sys_clk),
        .rst     (rst),
        .wr_en   (a.wr_en),
        .wr_idx  (a.wr_idx),
        .wr_data (a.wr_data),
        .rd_idx  (copy_idx),
        .rd_data (latch_q)
    );

    // Program copies one word per clock; a full row takes 32 cycles
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            copying  <= 1'b0;
            copy_idx <= 5'h00;
        end else if (a.prog && !copying) begin
            copying  <= 1'b1;
            copy_idx <= 5'h00;
        end else if (copying) begin
            copy_idx <= copy_idx + 5'h01;
            if (copy_idx == 5'h1F) begin
                copying <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (a.erase) begin
            for (int i = 0; i < ROW_WORDS; i++) begin
                mem[{row, 5'(i)}] <= 24'hFFFFFF;
            end
        end else if (copying) begin
            mem[{row, copy_idx}] <= latch_q;
        end
    end

    assign a.rd_data = mem[rd_w];
endmodule // pfsp_array

// ---- pfsp_array_if.sv ----
// Interface between sequencer and flash array
`timescale 1ns/1ps
interface pfsp_array_if;
    logic        wr_en;
    logic [4:0]  wr_idx;
    logic [23:0] wr_data;
    logic        erase;
    logic        prog;
    logic [23:0] row_addr;
    logic [23:0] rd_addr;
    logic [23:0] rd_data;
    modport seq (output wr_en, wr_idx, wr_data, erase, prog, row_addr,
                 rd_addr, input rd_data);
    modport arr (input wr_en, wr_idx, wr_data, erase, prog, row_addr,
                 rd_addr, output rd_data);
endinterface

// ---- pfsp_latch.sv ----
// Row write latches of one panel
`timescale 1ns/1ps
module pfsp_latch
    import pfsp_pkg::*;
#(
    parameter int unsigned WORDS = ROW_WORDS
) (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        wr_en,
    input  wire logic [4:0]  wr_idx,
    input  wire logic [23:0] wr_data,
    input  wire logic [4:0]  rd_idx,
    output logic [23:0]      rd_data
);
    logic [23:0] mem [WORDS];

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < WORDS; i++) begin
                mem[i] <= 24'hFFFFFF;
            end
        end else if (wr_en) begin
            mem[wr_idx] <= wr_data;
        end
    end

    assign rd_data = mem[rd_idx];
endmodule // pfsp_latch

// ---- pfsp_pkg.sv ----
// Package of constants and types for the program flash self-programming block
//
// Notes on behaviour
// - Erase and program act on one row of 32 words, 96 bytes.
// - A panel holds 128 rows, 4K words of 24 bits.
// - Each panel has 32 word latches filled upward from a 32-word boundary.
// - Low table accesses reach word bits 15..0, word or byte wide.
// - High table accesses reach word bits 23..16, word or byte wide.
// - Program address is page pointer low byte above the 16-bit address.
// - A table write touches only latches and takes two instruction cycles.
// - Each launch programs or erases exactly one row.
// - Low address register captures address bits 15..0 of last table access.
// - Upper address register captures address bits 23..16 of last access.
// - Software writes to the address registers set the target directly.
// - Key 0x55 then 0xAA must precede a start, otherwise no operation.
// - Control register selects erase or program, memory type, and start; the code erases on OP_ROW_ERASE, programs on any other op, no memory type.
// - Start bit 15 begins the operation and clears itself when done.
// - Operation lasts 2 ms and the processor stalls throughout.
package pfsp_pkg;
    localparam int unsigned CLK_MHZ         = 125;
    localparam int unsigned OP_TIME_US      = 2000;
    localparam int unsigned OP_CYCLES       = OP_TIME_US * CLK_MHZ;
    localparam int unsigned TBLWR_CYCLES    = 2;
    localparam int unsigned ROW_WORDS       = 32;
    localparam int unsigned PANEL_ROWS      = 128;
    localparam int unsigned PANEL_WORDS     = ROW_WORDS * PANEL_ROWS;
    localparam logic [3:0]  ADDR_CONTROL    = 4'h0;
    localparam logic [3:0]  ADDR_ADR_LOW    = 4'h1;
    localparam logic [3:0]  ADDR_ADR_UPPER  = 4'h2;
    localparam logic [3:0]  ADDR_KEY        = 4'h3;
    localparam logic [3:0]  ADDR_TABLE_PAGE_POINTER     = 4'h4;
    localparam int unsigned CTL_START_BIT   = 15;
    localparam int unsigned CTL_WRITE_ENABLE_BIT_BIT    = 14;
    localparam int unsigned CTL_ERR_BIT     = 13;
    localparam int unsigned CTL_OP_LSB      = 0;
    localparam logic [6:0]  OP_ROW_ERASE    = 7'h41;
    localparam logic [6:0]  OP_ROW_PROGRAM  = 7'h01;
    localparam logic [15:0] CONTROL_RESET   = 16'h0000;
    localparam logic [7:0]  KEY_FIRST       = 8'h55;
    localparam logic [7:0]  KEY_SECOND      = 8'hAA;
    typedef enum logic [1:0] {
        PFSP_KEY_IDLE,
        PFSP_KEY_ONE,
        PFSP_KEY_OPEN
    } pfsp_key_t;
    typedef enum logic [1:0] {
        PFSP_OP_IDLE,
        PFSP_OP_ERASE,
        PFSP_OP_PROGRAM
    } pfsp_op_t;
endpackage

// ---- pfsp_top.sv ----
// Self-programming sequencer: registers, unlock, table access and timing
//
// The address-and-strobe port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module pfsp_top
    import pfsp_pkg::*;
#(
    parameter int unsigned OP_COUNT = OP_CYCLES
) (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [15:0]      reg_rdata,
    input  wire logic        tbl_wr,
    input  wire logic        tbl_rd,
    input  wire logic        tbl_high,
    input  wire logic        tbl_byte,
    input  wire logic [15:0] tbl_ea,
    input  wire logic [15:0] tbl_wdata,
    output logic [15:0]      tbl_rdata,
    output logic             cpu_stall
);
    pfsp_array_if ai ();

    logic [15:0] control;
    logic [15:0] adr_low;
    logic [7:0]  adr_upper;
    logic [7:0]  table_page_pointer;
    pfsp_key_t   key_state;
    pfsp_op_t    op_state;
    logic [31:0] op_cnt;
    logic [1:0]  tw_cnt;
    logic [23:0] lat_shadow [ROW_WORDS];
    logic [23:0] rd_word;
    logic [23:0] tbl_addr;
    logic        start_req;
    logic        busy;

    assign tbl_addr = {table_page_pointer, tbl_ea};
    assign busy     = op_state != PFSP_OP_IDLE;
    assign start_req = reg_wr && reg_addr == ADDR_CONTROL
                       && reg_wdata[CTL_START_BIT] && !busy;

    // Merge new low or high bits into a 24-bit word
    function automatic logic [23:0] merge(input logic [23:0] old,
                                          input logic        high,
                                          input logic        bsel,
                                          input logic        odd,
                                          input logic [15:0] d);
        logic [23:0] w;
        w = old;
        if (high) begin
            w[23:16] = d[7:0];
        end else if (bsel) begin
            if (odd) begin
                w[15:8] = d[7:0];
            end else begin
                w[7:0] = d[7:0];
            end
        end else begin
            w[15:0] = d;
        end
        return w;
    endfunction

    // Unlock: 0x55 then 0xAA, each with no other register write between
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            key_state <= PFSP_KEY_IDLE;
        end else if (reg_wr) begin
            // A fresh first key always restarts, so a retry is never lost
            if (reg_addr == ADDR_KEY && reg_wdata[7:0] == KEY_FIRST) begin
                key_state <= PFSP_KEY_ONE;
            end else if (key_state == PFSP_KEY_ONE && reg_addr == ADDR_KEY
                         && reg_wdata[7:0] == KEY_SECOND) begin
                key_state <= PFSP_KEY_OPEN;
            end else begin
                key_state <= PFSP_KEY_IDLE;
            end
        end
    end

    // Control register; start bit is honoured only when unlocked
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            control <= CONTROL_RESET;
        end else if (busy && op_cnt == 32'd1) begin
            control[CTL_START_BIT] <= 1'b0;
        end else if (reg_wr && reg_addr == ADDR_CONTROL && !busy) begin
            control[CTL_WRITE_ENABLE_BIT_BIT] <= reg_wdata[CTL_WRITE_ENABLE_BIT_BIT];
            control[6:0]          <= reg_wdata[6:0];
            if (reg_wdata[CTL_START_BIT]) begin
                if (key_state == PFSP_KEY_OPEN
                    && reg_wdata[CTL_WRITE_ENABLE_BIT_BIT]) begin
                    control[CTL_START_BIT] <= 1'b1;
                    control[CTL_ERR_BIT]   <= 1'b0;
                end else begin
                    // Blocked start is flagged so software can see it
                    control[CTL_ERR_BIT]   <= 1'b1;
                end
            end else begin
                control[CTL_ERR_BIT] <= reg_wdata[CTL_ERR_BIT];
            end
        end
    end

    // Address registers: table capture or direct software write
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            adr_low   <= 16'h0000;
            adr_upper <= 8'h00;
        end else if ((tbl_wr || tbl_rd) && !busy) begin
            adr_low   <= tbl_addr[15:0];
            adr_upper <= tbl_addr[23:16];
        end else if (reg_wr && reg_addr == ADDR_ADR_LOW && !busy) begin
            adr_low   <= reg_wdata;
        end else if (reg_wr && reg_addr == ADDR_ADR_UPPER && !busy) begin
            adr_upper <= reg_wdata[7:0];
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            table_page_pointer <= 8'h00;
        end else if (reg_wr && reg_addr == ADDR_TABLE_PAGE_POINTER) begin
            table_page_pointer <= reg_wdata[7:0];
        end
    end

    // Operation timer; one launch acts on one row only
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            op_state <= PFSP_OP_IDLE;
            op_cnt   <= 32'd0;
        end else begin
            unique case (op_state)
                PFSP_OP_IDLE: begin
                    if (start_req && key_state == PFSP_KEY_OPEN
                        && reg_wdata[CTL_WRITE_ENABLE_BIT_BIT]) begin
                        op_cnt   <= OP_COUNT;
                        op_state <= (reg_wdata[6:0] == OP_ROW_ERASE)
                                    ? PFSP_OP_ERASE : PFSP_OP_PROGRAM;
                    end
                end
                PFSP_OP_ERASE, PFSP_OP_PROGRAM: begin
                    op_cnt <= op_cnt - 32'd1;
                    if (op_cnt == 32'd1)
                        op_state <= PFSP_OP_IDLE;
                end
            endcase
        end
    end

    // Table write occupies two instruction cycles of latch access only
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tw_cnt <= 2'd0;
        end else if (tbl_wr && !busy) begin
            tw_cnt <= 2'(TBLWR_CYCLES - 1);
        end else if (tw_cnt != 2'd0) begin
            tw_cnt <= tw_cnt - 2'd1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (tbl_wr && !busy) begin
            lat_shadow[tbl_ea[5:1]] <= merge(lat_shadow[tbl_ea[5:1]],
                tbl_high, tbl_byte, tbl_ea[0], tbl_wdata);
        end
    end

    assign ai.wr_en    = tbl_wr && !busy;
    assign ai.wr_idx   = tbl_ea[5:1];
    assign ai.wr_data  = merge(lat_shadow[tbl_ea[5:1]], tbl_high,
                               tbl_byte, tbl_ea[0], tbl_wdata);
    assign ai.erase    = op_state == PFSP_OP_ERASE && op_cnt == OP_COUNT;
    assign ai.prog     = op_state == PFSP_OP_PROGRAM && op_cnt == OP_COUNT;
    assign ai.row_addr = {adr_upper, adr_low[15:6], 6'h00};
    assign ai.rd_addr  = {1'b0, tbl_addr[23:1]};
    assign rd_word     = ai.rd_data;

    pfsp_array #(.ROWS(PANEL_ROWS)) u_array (
        .sys_clk (sys_clk),
        .rst     (rst),
        .a       (ai.arr)
    );

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tbl_rdata <= 16'h0000;
        end else if (tbl_rd && !busy) begin
            if (tbl_high)
                tbl_rdata <= {8'h00, rd_word[23:16]};
            else if (tbl_byte)
                tbl_rdata <= {8'h00, tbl_ea[0] ? rd_word[15:8]
                                               : rd_word[7:0]};
            else
                tbl_rdata <= rd_word[15:0];
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            unique case (reg_addr)
                ADDR_CONTROL:   reg_rdata <= control;
                ADDR_ADR_LOW:   reg_rdata <= adr_low;
                ADDR_ADR_UPPER: reg_rdata <= {8'h00, adr_upper};
                ADDR_TABLE_PAGE_POINTER:    reg_rdata <= {8'h00, table_page_pointer};
                default:        reg_rdata <= 16'h0000; // Key is write-only
            endcase
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    // Stall while an operation or a table write is still in progress
    assign cpu_stall = busy || tw_cnt != 2'd0;

    default clocking cb_sys @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    // Unlock steps, one register write each on consecutive cycles
    sequence key_first_s;
        reg_wr && reg_addr == ADDR_KEY && reg_wdata[7:0] == KEY_FIRST;
    endsequence
    sequence key_second_s;
        reg_wr && reg_addr == ADDR_KEY && reg_wdata[7:0] == KEY_SECOND;
    endsequence
    sequence armed_start_s;
        start_req && reg_wdata[CTL_WRITE_ENABLE_BIT_BIT];
    endsequence

    AST_UNLOCK_START: assert property (
        key_first_s ##1 key_second_s ##1 armed_start_s |=> busy)
        else $error("unlocked start not honoured");
    AST_NO_START_LOCKED: assert property (
        start_req && key_state != PFSP_KEY_OPEN |=> !busy)
        else $error("start accepted without unlock");
    AST_STALL_BUSY: assert property (
        busy |-> cpu_stall && control[CTL_START_BIT])
        else $error("stall or start bit dropped while busy");
    AST_SELF_CLEAR: assert property (
        $fell(busy) |-> !control[CTL_START_BIT])
        else $error("start bit not cleared at end");
    AST_KEY_CANCEL: assert property (
        key_state == PFSP_KEY_ONE && reg_wr && reg_addr != ADDR_KEY
        |=> key_state == PFSP_KEY_IDLE)
        else $error("unlock not cancelled");
    AST_CAPTURE: assert property (
        tbl_wr && !busy |=> adr_low == $past(tbl_ea)
        && adr_upper == $past(table_page_pointer))
        else $error("address not captured");
    AST_TW_TWO: assert property (
        tbl_wr && !busy |=> cpu_stall)
        else $error("table write not two cycles");
    AST_ONE_ROW: assert property (
        ai.erase |=> !ai.erase)
        else $error("more than one erase per launch");
    AST_HIGH_RD: assert property (
        tbl_rd && tbl_high && !busy |=> tbl_rdata[15:8] == 8'h00)
        else $error("high read wider than 8 bits");
endmodule // pfsp_top

// ---- pfsp_top_tb.sv ----
// Self-checking testbench for the self-programming sequencer
`timescale 1ns/1ps
module pfsp_top_tb;
    import pfsp_pkg::*;
    // Short operation count keeps the run brief
    localparam int unsigned OPN = 50;
    logic        sys_clk;
    logic        rst;
    logic [3:0]  reg_addr;
    logic [15:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [15:0] reg_rdata;
    logic        tbl_wr;
    logic        tbl_rd;
    logic        tbl_high;
    logic        tbl_byte;
    logic [15:0] tbl_ea;
    logic [15:0] tbl_wdata;
    logic [15:0] tbl_rdata;
    logic        cpu_stall;
    int          fails;
    int          compares;

    pfsp_top #(.OP_COUNT(OPN)) u_pfsp_top (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .reg_addr  (reg_addr),
        .reg_wdata (reg_wdata),
        .reg_wr    (reg_wr),
        .reg_rd    (reg_rd),
        .reg_rdata (reg_rdata),
        .tbl_wr    (tbl_wr),
        .tbl_rd    (tbl_rd),
        .tbl_high  (tbl_high),
        .tbl_byte  (tbl_byte),
        .tbl_ea    (tbl_ea),
        .tbl_wdata (tbl_wdata),
        .tbl_rdata (tbl_rdata),
        .cpu_stall (cpu_stall)
    );

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    task automatic summarize();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check16(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic stall_is(input logic v);
        check16({15'h0000, cpu_stall}, {15'h0000, v});
    endtask

    task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
    endtask

    // Four writes with no gap, so unlock steps stay adjacent
    task automatic reg_burst(input logic [3:0] a[4], input logic [15:0] d[4]);
        for (int i = 0; i < 4; i++) begin
            @(posedge sys_clk);
            reg_addr  <= a[i];
            reg_wdata <= d[i];
            reg_wr    <= 1'b1;
        end
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [3:0] a, output logic [15:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic reg_expect(input logic [3:0] a, input logic [15:0] m,
                              input logic [15:0] exp);
        logic [15:0] r;
        reg_read(a, r);
        check16(r & m, exp);
    endtask

    // Stall must cover exactly the second cycle of a table write
    task automatic tbl_write(input logic hi, input logic [15:0] ea,
                             input logic [15:0] d);
        @(posedge sys_clk);
        tbl_wr    <= 1'b1;
        tbl_high  <= hi;
        tbl_ea    <= ea;
        tbl_wdata <= d;
        @(posedge sys_clk);
        tbl_wr    <= 1'b0;
        #1 stall_is(1'b1);
        @(posedge sys_clk);
        #1 stall_is(1'b0);
    endtask

    task automatic tbl_expect(input logic hi, input logic [15:0] ea,
                              input logic [15:0] exp);
        @(posedge sys_clk);
        tbl_rd   <= 1'b1;
        tbl_high <= hi;
        tbl_ea   <= ea;
        @(posedge sys_clk);
        tbl_rd   <= 1'b0;
        #1 check16(tbl_rdata, exp);
    endtask

    task automatic run_op(input logic [15:0] adr, input logic [15:0] ctl,
                          input bit count);
        int n;
        reg_burst('{ADDR_ADR_LOW, ADDR_KEY, ADDR_KEY, ADDR_CONTROL},
                  '{adr, {8'h00, KEY_FIRST}, {8'h00, KEY_SECOND}, ctl});
        #1 stall_is(1'b1);
        if (!count) reg_expect(ADDR_CONTROL, 16'h8000, 16'h8000);
        n = 0;
        while (cpu_stall === 1'b1 && n < 4 * OPN) begin
            @(posedge sys_clk);
            #1 n++;
        end
        if (count) check16(16'(n), 16'(OPN));
        reg_expect(ADDR_CONTROL, 16'h8000, 16'h0000);
    endtask

    task automatic refuse(input logic [3:0] a[4], input logic [15:0] d[4]);
        reg_burst(a, d);
        #1 stall_is(1'b0);
        reg_expect(ADDR_CONTROL, 16'hA000, 16'h2000);
    endtask

    // Erase, fill latches upward from word 0, then program the row
    task automatic do_row(input logic [15:0] base, input logic [15:0] lb,
                          input logic [15:0] hb);
        run_op(base, {2'b11, 7'h00, OP_ROW_ERASE}, 1'b1);
        for (int i = 0; i < ROW_WORDS; i++) begin
            tbl_write(1'b0, base + 16'(2 * i), lb + 16'(i));
            tbl_write(1'b1, base + 16'(2 * i), hb + 16'(i));
        end
        run_op(base, {2'b11, 7'h00, OP_ROW_PROGRAM}, 1'b0);
    endtask

    task automatic verify_row(input logic [15:0] base, input logic [15:0] lb,
                              input logic [15:0] hb);
        for (int i = 0; i < ROW_WORDS; i++) begin
            tbl_expect(1'b0, base + 16'(2 * i), lb + 16'(i));
            tbl_expect(1'b1, base + 16'(2 * i), hb + 16'(i));
        end
    endtask

    task automatic end_test(input string s);
        $display("test %s done", s);
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk);
        fails++;
        summarize();
    end

    initial begin
        rst = 1'b1;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        tbl_wr = 1'b0;
        tbl_rd = 1'b0;
        tbl_high = 1'b0;
        tbl_byte = 1'b0;
        tbl_ea = 16'h0000;
        tbl_wdata = 16'h0000;
        fails = 0;
        compares = 0;
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        reg_expect(ADDR_CONTROL, 16'hFFFF, CONTROL_RESET);
        reg_expect(ADDR_KEY, 16'hFFFF, 16'h0000);
        stall_is(1'b0);
        end_test("reset");
        reg_write(ADDR_ADR_LOW, 16'h1234);
        reg_expect(ADDR_ADR_LOW, 16'hFFFF, 16'h1234);
        reg_write(ADDR_ADR_UPPER, 16'hFFAB);
        reg_expect(ADDR_ADR_UPPER, 16'hFFFF, 16'h00AB);
        end_test("address registers");
        reg_write(ADDR_TABLE_PAGE_POINTER, 16'h0005);
        tbl_write(1'b0, 16'h0042, 16'h1111);
        reg_expect(ADDR_ADR_LOW, 16'hFFFF, 16'h0042);
        reg_expect(ADDR_ADR_UPPER, 16'hFFFF, 16'h0005);
        reg_write(ADDR_TABLE_PAGE_POINTER, 16'h0000);
        reg_write(ADDR_ADR_UPPER, 16'h0000);
        end_test("address capture");
        refuse('{ADDR_ADR_LOW, ADDR_KEY, ADDR_KEY, ADDR_CONTROL},
               '{16'h0040, 16'h00AA, 16'h0055, 16'hC041});
        refuse('{ADDR_KEY, ADDR_ADR_LOW, ADDR_KEY, ADDR_CONTROL},
               '{16'h0055, 16'h0040, 16'h00AA, 16'hC041});
        refuse('{ADDR_KEY, ADDR_KEY, ADDR_ADR_LOW, ADDR_CONTROL},
               '{16'h0055, 16'h00AA, 16'h0040, 16'hC041});
        refuse('{ADDR_ADR_LOW, ADDR_KEY, ADDR_KEY, ADDR_CONTROL},
               '{16'h0040, 16'h0055, 16'h00AA, 16'h8041});
        end_test("refused starts");
        do_row(16'h0040, 16'hA500, 16'h0030);
        verify_row(16'h0040, 16'hA500, 16'h0030);
        // Second row must leave the first one intact
        do_row(16'h0000, 16'h5A00, 16'h0060);
        verify_row(16'h0000, 16'h5A00, 16'h0060);
        verify_row(16'h0040, 16'hA500, 16'h0030);
        end_test("row erase and program");
        // Byte reads pick one lane of the low word by address bit 0
        @(posedge sys_clk);
        tbl_byte <= 1'b1;
        tbl_expect(1'b0, 16'h0041, 16'h00A5);
        tbl_expect(1'b0, 16'h0042, 16'h0001);
        tbl_expect(1'b0, 16'h0001, 16'h005A);
        @(posedge sys_clk);
        tbl_byte <= 1'b0;
        end_test("byte reads");
        summarize();
    end
endmodule // pfsp_top_tb
